/* File: verilog/sfe_defines.vh */
// constants shared by the serial flash erase / power / identification command block
`ifndef SFE_DEFINES_VH
`define SFE_DEFINES_VH

// reference clock rate used to turn times into cycle counts
`define SFE_CLK_MHZ 10

// opcodes handled by this block
`define SFE_OP_WRITE_LATCH_SET_CMD 8'h06
`define SFE_OP_ERASE_A 8'h60
`define SFE_OP_ERASE_B 8'hC7
`define SFE_OP_RB_ON 8'h70
`define SFE_OP_RB_OFF 8'h80
`define SFE_OP_SLEEP 8'hB9
`define SFE_OP_WAKE_ID 8'hAB
`define SFE_OP_MPID_X1 8'h90
`define SFE_OP_MPID_X2 8'h92
`define SFE_OP_MPID_X4 8'h94
`define SFE_OP_FULL_ID 8'h9F

// frame bit counts and the id byte-swap address
`define SFE_OPCODE_BITS 6'h08
`define SFE_OPCODE_LAST 5'h07
`define SFE_ADDR_BITS 5'h18
`define SFE_DUMMY_LAST 5'h17
`define SFE_TOTAL_MAX 6'h3F
`define SFE_ADDR_SWAP 24'h00_0001

// identification output lengths in bits
`define SFE_LEN_ONE 5'h08
`define SFE_LEN_TWO 5'h10
`define SFE_LEN_THREE 5'h18

// lane counts
`define SFE_LANES_X1 3'h1
`define SFE_LANES_X2 3'h2
`define SFE_LANES_X4 3'h4

// self-timed delays, in microseconds; plain defaults, not characterised figures
`define SFE_T_POWERUP_US 10
`define SFE_T_ERASE_US 20000
`define SFE_T_SLEEP_ENTRY_US 3
`define SFE_T_WAKE_SHORT_US 3
`define SFE_T_WAKE_LONG_US 5

// reset values
`define SFE_IO_IDLE 4'h0
`define SFE_OE_OFF 4'hF

`endif

/* File: verilog/sfe_timer.v */
// down-counting delay timer used for every self-timed interval of the block
`timescale 1ns/1ps
module sfe_timer #(
   parameter W = 32
) (
   input wire ref_clk_i,
   input wire reset_n_i,
   input wire load_i,
   input wire [W-1:0] count_i,
   output wire running_o,
   output wire done_o
);
   reg [W-1:0] cnt_r; // cycles still to wait
   reg done_r; // one-cycle pulse at the end of the wait

   // a load restarts the wait; a count of one ends at the next edge
   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_r <= {W{1'b0}};
         done_r <= 1'b0;
      end else if (load_i) begin
         cnt_r <= count_i;
         done_r <= 1'b0;
      end else begin
         done_r <= (cnt_r == {{(W-1){1'b0}}, 1'b1});
         if (cnt_r != {W{1'b0}}) begin
            cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
         end
      end
   end

   assign running_o = (cnt_r != {W{1'b0}});
   assign done_o = done_r;
endmodule

/* File: verilog/sfe_cmd.v */
// command handling for full erase, ready/busy output, deep sleep and identification reads
//
// Notes on behaviour
// RULE1 - full erase by 60H/C7H, needs write latch
// RULE2 - erase only if frame ends after opcode
// RULE3 - erase sets busy flag, clears write latch
// RULE4 - erase only when protect bits match invert
// RULE5 - 70H: output pin shows ready or busy
// RULE6 - 80H: output pin back to data role
// RULE7 - 70H/80H only when frame ends after opcode
// RULE8 - B9H enters deep sleep after entry delay
// RULE9 - in deep sleep only wake command works
// RULE10 - sleep command rejected while cycle runs
// RULE11 - idle deselect is standby; reset gives standby
// RULE12 - host waits short delay after bare wake
// RULE13 - ABH plus 3 dummies repeats device id
// RULE14 - host waits long delay after id wake
// RULE15 - wake/id command ignored while busy
// RULE16 - 90H address zero: maker then device id
// RULE17 - address one swaps id byte order
// RULE18 - 92H/94H use two or four lanes
// RULE19 - 9FH gives maker, type, capacity bytes
// RULE20 - 9FH not decoded during erase cycle
// RULE21 - host avoids 9FH during deep sleep
// RULE22 - input bits taken on rising clock, msb first
`timescale 1ns/1ps
`include "sfe_defines.vh"
module sfe_cmd #(
   parameter [7:0] MAKER_ID = 8'h5A, // arbitrary value
   parameter [7:0] DEVICE_ID = 8'h3C, // arbitrary value
   parameter [7:0] MEM_TYPE = 8'h60, // arbitrary value
   parameter [7:0] CAPACITY = 8'h15, // arbitrary value
   parameter TW = 32,
   parameter POWERUP_CYCLES = `SFE_T_POWERUP_US * `SFE_CLK_MHZ,
   parameter ERASE_CYCLES = `SFE_T_ERASE_US * `SFE_CLK_MHZ,
   parameter SLEEP_ENTRY_CYCLES = `SFE_T_SLEEP_ENTRY_US * `SFE_CLK_MHZ,
   parameter WAKE_SHORT_CYCLES = `SFE_T_WAKE_SHORT_US * `SFE_CLK_MHZ,
   parameter WAKE_LONG_CYCLES = `SFE_T_WAKE_LONG_US * `SFE_CLK_MHZ
) (
   input wire ref_clk_i,
   input wire reset_n_i,
   input wire cs_n_i,
   input wire sclk_i,
   input wire [3:0] io_i,
   output wire [3:0] io_o,
   output wire [3:0] io_oe_n_o,
   input wire [2:0] protect_level_bits_i,
   input wire protect_invert_bit_i,
   output wire write_enable_latch_o,
   output wire program_busy_flag_o,
   output wire deep_sleep_o,
   output wire standby_o,
   output wire busy_output_enable_o,
   output wire erase_all_o,
   output wire erase_done_o
);
   // device states
   localparam [2:0] ST_POWERUP = 3'h0;
   localparam [2:0] ST_STANDBY = 3'h1;
   localparam [2:0] ST_ERASING = 3'h2;
   localparam [2:0] ST_SLEEP_IN = 3'h3;
   localparam [2:0] ST_SLEEP = 3'h4;
   localparam [2:0] ST_WAKING = 3'h5;
   // frame phases
   localparam [2:0] PH_CMD = 3'h0;
   localparam [2:0] PH_ADDR = 3'h1;
   localparam [2:0] PH_DUMMY = 3'h2;
   localparam [2:0] PH_OUT = 3'h3;
   localparam [2:0] PH_IGN = 3'h4;

   // shift w lanes into the low end of a 24-bit register, msb lane first
   function [23:0] sfe_shin;
      input [23:0] sh;
      input [3:0] io;
      input [2:0] w;
      begin
         if (w == `SFE_LANES_X4) begin
            sfe_shin = {sh[19:0], io};
         end else if (w == `SFE_LANES_X2) begin
            sfe_shin = {sh[21:0], io[1], io[0]};
         end else begin
            sfe_shin = {sh[22:0], io[0]};
         end
      end
   endfunction

   // pick the next w bits of a left-aligned word for the lanes
   function [3:0] sfe_pick;
      input [23:0] word;
      input [4:0] idx;
      input [2:0] w;
      reg [23:0] sh;
      begin
         sh = word << idx;
         if (w == `SFE_LANES_X4) begin
            sfe_pick = sh[23:20];
         end else if (w == `SFE_LANES_X2) begin
            sfe_pick = {2'b00, sh[23], sh[22]};
         end else begin
            sfe_pick = {2'b00, sh[23], 1'b0};
         end
      end
   endfunction

   // lanes that the device drives during identifier output
   function [3:0] sfe_oe_n;
      input [2:0] w;
      begin
         if (w == `SFE_LANES_X4) begin
            sfe_oe_n = 4'h0;
         end else if (w == `SFE_LANES_X2) begin
            sfe_oe_n = 4'hC;
         end else begin
            sfe_oe_n = 4'hD;
         end
      end
   endfunction

   // erase is allowed only for the two unprotected patterns
   function sfe_prot_ok;
      input [2:0] lvl;
      input inv;
      begin
         sfe_prot_ok = ((lvl == 3'h0) && !inv) || ((lvl == 3'h7) && inv); // RULE4
      end
   endfunction

   // two-stage synchronisers for the pins; the third stage feeds edge detection
   reg cs_s1_r, cs_s2_r, cs_s3_r;
   reg ck_s1_r, ck_s2_r, ck_s3_r;
   reg [3:0] io_s1_r, io_s2_r;

   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cs_s1_r <= 1'b1;
         cs_s2_r <= 1'b1;
         cs_s3_r <= 1'b1;
         ck_s1_r <= 1'b0;
         ck_s2_r <= 1'b0;
         ck_s3_r <= 1'b0;
         io_s1_r <= `SFE_IO_IDLE;
         io_s2_r <= `SFE_IO_IDLE;
      end else begin
         cs_s1_r <= cs_n_i;
         cs_s2_r <= cs_s1_r;
         cs_s3_r <= cs_s2_r;
         ck_s1_r <= sclk_i;
         ck_s2_r <= ck_s1_r;
         ck_s3_r <= ck_s2_r;
         io_s1_r <= io_i;
         io_s2_r <= io_s1_r;
      end
   end

   wire sel = !cs_s2_r; // chip selected, synchronised
   wire frame_start = !cs_s2_r && cs_s3_r; // select falling
   wire frame_end = cs_s2_r && !cs_s3_r; // select rising
   wire ck_rise = sel && ck_s2_r && !ck_s3_r;
   wire ck_fall = sel && !ck_s2_r && ck_s3_r;

   reg [2:0] state_r; // device state
   wire in_sleep = (state_r == ST_SLEEP);
   wire busy = (state_r != ST_STANDBY) && (state_r != ST_SLEEP);
   wire erasing = (state_r == ST_ERASING);

   // frame decoder
   reg [2:0] ph_r; // phase within the frame
   reg [7:0] op_r; // latched opcode
   reg [4:0] cnt_r; // bits taken within the phase
   reg [5:0] tot_r; // rising clocks taken in the frame, saturating
   reg [2:0] lanes_r; // lanes used after the opcode
   reg [23:0] in_sh_r; // input shift register
   reg [23:0] out_word_r; // identifier bytes, left aligned
   reg [4:0] out_len_r; // length of one repeat of the output word
   reg [4:0] out_idx_r; // next output bit position
   reg [3:0] io_r; // output lane values
   reg out_on_r; // output lanes owned by the frame
   wire [23:0] sh_nxt = sfe_shin(in_sh_r, io_s2_r, (ph_r == PH_CMD) ? `SFE_LANES_X1 : lanes_r);
   wire [4:0] cnt_nxt = cnt_r + {2'b00, (ph_r == PH_CMD) ? `SFE_LANES_X1 : lanes_r};
   wire [4:0] idx_nxt = out_idx_r + {2'b00, lanes_r};

   // bits come in on rising clock, go out on falling clock, msb first
   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ph_r <= PH_IGN;
         op_r <= 8'h00;
         cnt_r <= 5'h00;
         tot_r <= 6'h00;
         lanes_r <= `SFE_LANES_X1;
         in_sh_r <= 24'h00_0000;
         out_word_r <= 24'h00_0000;
         out_len_r <= `SFE_LEN_ONE;
         out_idx_r <= 5'h00;
         io_r <= `SFE_IO_IDLE;
         out_on_r <= 1'b0;
      end else if (frame_start) begin
         // a new frame always starts with a single-lane opcode
         ph_r <= PH_CMD;
         cnt_r <= 5'h00;
         tot_r <= 6'h00;
         lanes_r <= `SFE_LANES_X1;
         out_idx_r <= 5'h00;
         out_on_r <= 1'b0;
      end else if (!sel) begin
         out_on_r <= 1'b0;
      end else if (ck_rise) begin
         if (tot_r != `SFE_TOTAL_MAX) begin
            tot_r <= tot_r + 6'h01;
         end
         in_sh_r <= sh_nxt; // RULE22
         cnt_r <= cnt_nxt;
         case (ph_r)
            PH_CMD: begin
               if (cnt_r == `SFE_OPCODE_LAST) begin
                  op_r <= sh_nxt[7:0];
                  cnt_r <= 5'h00;
                  ph_r <= PH_IGN; // opcode-only commands act at frame end
                  if (in_sleep) begin
                     if (sh_nxt[7:0] == `SFE_OP_WAKE_ID) begin
                        ph_r <= PH_DUMMY; // RULE9
                     end
                  end else if (sh_nxt[7:0] == `SFE_OP_WAKE_ID) begin
                     if (!busy) begin
                        ph_r <= PH_DUMMY; // RULE15
                     end
                  end else if (sh_nxt[7:0] == `SFE_OP_MPID_X1) begin
                     ph_r <= PH_ADDR; // RULE16
                  end else if (sh_nxt[7:0] == `SFE_OP_MPID_X2) begin
                     ph_r <= PH_ADDR; // RULE18
                     lanes_r <= `SFE_LANES_X2;
                  end else if (sh_nxt[7:0] == `SFE_OP_MPID_X4) begin
                     ph_r <= PH_ADDR; // RULE18
                     lanes_r <= `SFE_LANES_X4;
                  end else if (sh_nxt[7:0] == `SFE_OP_FULL_ID) begin
                     if (!erasing) begin
                        ph_r <= PH_OUT; // RULE20
                        out_word_r <= {MAKER_ID, MEM_TYPE, CAPACITY}; // RULE19
                        out_len_r <= `SFE_LEN_THREE;
                     end
                  end
               end
            end
            PH_ADDR: begin
               if (cnt_nxt == `SFE_ADDR_BITS) begin
                  ph_r <= PH_OUT;
                  out_len_r <= `SFE_LEN_TWO;
                  if (sh_nxt == `SFE_ADDR_SWAP) begin
                     out_word_r <= {DEVICE_ID, MAKER_ID, 8'h00}; // RULE17
                  end else begin
                     out_word_r <= {MAKER_ID, DEVICE_ID, 8'h00}; // RULE16
                  end
               end
            end
            PH_DUMMY: begin
               if (cnt_r == `SFE_DUMMY_LAST) begin
                  ph_r <= PH_OUT; // RULE13
                  out_word_r <= {DEVICE_ID, 16'h0000};
                  out_len_r <= `SFE_LEN_ONE;
               end
            end
            default: begin
               ph_r <= ph_r; // output or ignored frames take no more input
            end
         endcase
      end else if (ck_fall && (ph_r == PH_OUT)) begin
         // the word repeats until select rises, so a long read wraps
         io_r <= sfe_pick(out_word_r, out_idx_r, lanes_r); // RULE13
         out_on_r <= 1'b1;
         if (idx_nxt == out_len_r) begin
            out_idx_r <= 5'h00;
         end else begin
            out_idx_r <= idx_nxt;
         end
      end
   end

   // device state, write latch and ready/busy enable
   reg wel_r; // write enable latch
   reg rb_en_r; // ready/busy shown on the output pin
   reg pu_go_r; // power-up wait not yet started
   reg t_load_r; // timer load strobe
   reg [TW-1:0] t_val_r; // timer load value
   reg erase_all_r; // one-cycle erase start pulse
   reg erase_done_r; // one-cycle erase end pulse
   wire t_done;
   wire t_run;
   wire op_only = (tot_r == `SFE_OPCODE_BITS); // frame ended right after the opcode
   wire erase_op = (op_r == `SFE_OP_ERASE_A) || (op_r == `SFE_OP_ERASE_B);

   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_r <= ST_POWERUP;
         wel_r <= 1'b0;
         rb_en_r <= 1'b0;
         pu_go_r <= 1'b1;
         t_load_r <= 1'b0;
         t_val_r <= {TW{1'b0}};
         erase_all_r <= 1'b0;
         erase_done_r <= 1'b0;
      end else begin
         t_load_r <= 1'b0;
         erase_all_r <= 1'b0;
         erase_done_r <= 1'b0;
         case (state_r)
            ST_POWERUP: begin
               // reset is power-up: wait, then land in standby
               if (pu_go_r) begin
                  pu_go_r <= 1'b0;
                  t_load_r <= 1'b1;
                  t_val_r <= POWERUP_CYCLES;
               end else if (t_done) begin
                  state_r <= ST_STANDBY; // RULE11
               end
            end
            ST_STANDBY: begin
               if (frame_end && op_only) begin
                  if (op_r == `SFE_OP_WRITE_LATCH_SET_CMD) begin
                     wel_r <= 1'b1;
                  end else if (erase_op) begin
                     // no latch or protected array: the erase is dropped
                     if (wel_r && sfe_prot_ok(protect_level_bits_i, protect_invert_bit_i)) begin
                        state_r <= ST_ERASING; // RULE1 RULE2
                        t_load_r <= 1'b1;
                        t_val_r <= ERASE_CYCLES;
                        erase_all_r <= 1'b1;
                        wel_r <= 1'b0; // RULE3
                     end
                  end else if (op_r == `SFE_OP_SLEEP) begin
                     state_r <= ST_SLEEP_IN; // RULE8
                     t_load_r <= 1'b1;
                     t_val_r <= SLEEP_ENTRY_CYCLES;
                  end
               end
            end
            ST_ERASING: begin
               // a sleep request here never reaches the sleep branch
               if (t_done) begin
                  state_r <= ST_STANDBY; // RULE3 RULE10
                  erase_done_r <= 1'b1;
               end
            end
            ST_SLEEP_IN: begin
               if (t_done) begin
                  state_r <= ST_SLEEP; // RULE8
               end
            end
            ST_SLEEP: begin
               if (frame_end && (op_r == `SFE_OP_WAKE_ID)) begin
                  if (op_only) begin
                     state_r <= ST_WAKING; // RULE12
                     t_load_r <= 1'b1;
                     t_val_r <= WAKE_SHORT_CYCLES;
                  end else if (ph_r == PH_OUT) begin
                     state_r <= ST_WAKING; // RULE14
                     t_load_r <= 1'b1;
                     t_val_r <= WAKE_LONG_CYCLES;
                  end
               end
            end
            ST_WAKING: begin
               if (t_done) begin
                  state_r <= ST_STANDBY;
               end
            end
            default: begin
               state_r <= ST_STANDBY;
            end
         endcase
         // ready/busy enable is honoured in every state but deep sleep
         if (frame_end && op_only && !in_sleep) begin
            if (op_r == `SFE_OP_RB_ON) begin
               rb_en_r <= 1'b1; // RULE5 RULE7
            end else if (op_r == `SFE_OP_RB_OFF) begin
               rb_en_r <= 1'b0; // RULE6 RULE7
            end
         end
      end
   end

   // one timer covers all self-timed intervals; they never overlap
   sfe_timer #(
      .W(TW)
   ) u_timer (
      .ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i),
      .load_i(t_load_r),
      .count_i(t_val_r),
      .running_o(t_run),
      .done_o(t_done)
   );

   // pin drive registers; frame output wins over the ready/busy level
   reg [3:0] io_o_r;
   reg [3:0] oe_n_r;

   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         io_o_r <= `SFE_IO_IDLE;
         oe_n_r <= `SFE_OE_OFF;
      end else if (out_on_r && sel) begin
         io_o_r <= io_r;
         oe_n_r <= sfe_oe_n(lanes_r);
      end else if (rb_en_r && (!sel || (lanes_r == `SFE_LANES_X1))) begin
         // wide frames read the output pin as an input lane
         // ready only in standby; busy also covers deep sleep and the timed waits
         io_o_r <= {2'b00, (state_r == ST_STANDBY), 1'b0}; // RULE5
         oe_n_r <= 4'hD;
      end else begin
         io_o_r <= `SFE_IO_IDLE; // RULE6
         oe_n_r <= `SFE_OE_OFF;
      end
   end

   assign io_o = io_o_r;
   assign io_oe_n_o = oe_n_r;
   assign write_enable_latch_o = wel_r;
   assign program_busy_flag_o = erasing && t_run; // RULE3
   assign deep_sleep_o = in_sleep;
   assign standby_o = (state_r == ST_STANDBY) && !sel; // RULE11
   assign busy_output_enable_o = rb_en_r;
   assign erase_all_o = erase_all_r;
   assign erase_done_o = erase_done_r;
endmodule

/* File: verification/sfe_cmd_chk.sv */
// concurrent checks on the ports of the erase / power / id command block
`timescale 1ns/1ps
module sfe_cmd_chk #(
   parameter ERASE_CYCLES = 400
) (
   input wire ref_clk_i,
   input wire reset_n_i,
   input wire cs_n_i,
   input wire [3:0] io_o,
   input wire [3:0] io_oe_n_o,
   input wire [2:0] protect_level_bits_i,
   input wire protect_invert_bit_i,
   input wire write_enable_latch_o,
   input wire program_busy_flag_o,
   input wire deep_sleep_o,
   input wire standby_o,
   input wire busy_output_enable_o,
   input wire erase_all_o,
   input wire erase_done_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);
   logic [15:0] bcnt_r; // cycles the busy flag has stood high
   // busy run length; a timer short by one cycle or long by more than two cycles shows here
   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bcnt_r <= 16'h0000;
      end else if (program_busy_flag_o) begin
         bcnt_r <= bcnt_r + 16'h0001;
      end else begin
         bcnt_r <= 16'h0000;
      end
   end
   a_erase_needs_wel: assert property (erase_all_o |-> $past(write_enable_latch_o))
      else $error("erase began without the write latch");
   a_erase_protect: assert property (erase_all_o |-> (protect_level_bits_i == 3'h0 &&
      !protect_invert_bit_i) || (protect_level_bits_i == 3'h7 && protect_invert_bit_i))
      else $error("erase began under protection");
   a_erase_sets_busy: assert property (erase_all_o |=> program_busy_flag_o)
      else $error("busy flag missing after erase start");
   a_wel_clears: assert property (erase_all_o |-> ##[0:2] !write_enable_latch_o)
      else $error("write latch kept through erase");
   a_busy_length: assert property ($fell(program_busy_flag_o) |->
      bcnt_r >= ERASE_CYCLES && bcnt_r <= ERASE_CYCLES + 2)
      else $error("erase time wrong");
   a_done_ends_busy: assert property (erase_done_o |-> ##[0:1] !program_busy_flag_o)
      else $error("busy stays after done");
   a_rb_ready: assert property ((busy_output_enable_o && standby_o) [*6] |->
      !io_oe_n_o[1] && io_o[1])
      else $error("ready not shown on output pin");
   a_rb_busy: assert property ((busy_output_enable_o && program_busy_flag_o) [*6] |->
      !io_oe_n_o[1] && !io_o[1])
      else $error("busy not shown on output pin");
   a_rb_off: assert property ((!busy_output_enable_o && cs_n_i) [*8] |->
      io_oe_n_o == 4'hF)
      else $error("output pin driven while deselected");
   a_sleep_idle: assert property ($rose(deep_sleep_o) |-> !program_busy_flag_o && cs_n_i)
      else $error("sleep entered during a cycle");
   a_sleep_quiet: assert property (deep_sleep_o |-> !erase_all_o && !standby_o)
      else $error("activity in deep sleep");
   c_erase: cover property (erase_all_o);
   c_sleep: cover property ($rose(deep_sleep_o));
   c_rb_busy: cover property (busy_output_enable_o && program_busy_flag_o);
endmodule
bind sfe_cmd sfe_cmd_chk #(.ERASE_CYCLES(ERASE_CYCLES)) sfe_cmd_chk_i (
   .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .cs_n_i(cs_n_i), .io_o(io_o),
   .io_oe_n_o(io_oe_n_o), .protect_level_bits_i(protect_level_bits_i),
   .protect_invert_bit_i(protect_invert_bit_i), .write_enable_latch_o(write_enable_latch_o),
   .program_busy_flag_o(program_busy_flag_o), .deep_sleep_o(deep_sleep_o),
   .standby_o(standby_o), .busy_output_enable_o(busy_output_enable_o),
   .erase_all_o(erase_all_o), .erase_done_o(erase_done_o));

/* File: verification/sfe_host_model.sv */
// host serial controller model: frames opcodes, addresses and reads answers
`timescale 1ns/1ps
module sfe_host_model (
   input wire ref_clk_i,
   input wire [3:0] io_pin_i,
   output logic cs_n_o,
   output logic sclk_o,
   output wire [3:0] io_drv_o
);
   logic [3:0] val = 4'h0; // value on lanes the host drives
   logic [3:0] en = 4'h0; // lanes the host drives
   logic flt = 1'b0; // released lanes toggle so a stale value never reads as data
   logic [3:0] smp; // lanes seen just before a falling edge
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0; // link clock stands still outside frames
   end
   always @(posedge ref_clk_i) begin
      flt <= ~flt;
   end
   assign io_drv_o = (val & en) | ({4{flt}} & ~en);
   // half a link period of 800 ns, changes just after a ref edge
   task automatic half();
      repeat (4) @(posedge ref_clk_i);
      #1;
   endtask
   // one link clock: data set while low, sampled by the device on the rise
   task automatic cyc(input logic [3:0] v, input logic [3:0] e);
      val = v;
      en = e;
      half();
      sclk_o = 1'b1;
      half();
      smp = io_pin_i;
      sclk_o = 1'b0;
   endtask
   // whole frame: opcode on IO0, abits of address over lanes, then ncyc read clocks
   task automatic xfer(input logic [7:0] op, input int abits, input logic [23:0] addr,
      input int lanes, input int ncyc, output logic [47:0] got);
      logic [23:0] a;
      logic [3:0] m;
      a = addr;
      m = 4'((1 << lanes) - 1);
      got = 48'h0000_0000_0000;
      cs_n_o = 1'b0;
      for (int i = 7; i >= 0; i--) cyc({3'h0, op[i]}, 4'h1);
      for (int i = 0; i < abits / lanes; i++) begin
         cyc(a[23:20] >> (4 - lanes), m);
         a = a << lanes;
      end
      for (int i = 0; i < ncyc; i++) begin
         cyc(4'h0, 4'h0);
         got = (got << lanes) | ((lanes == 1) ? {47'h0, smp[1]} : {44'h0, smp & m});
      end
      en = 4'h0;
      half();
      cs_n_o = 1'b1;
      half();
   endtask
endmodule

/* File: verification/tb.sv */
// self-checking bench for the erase / power / id command block
`timescale 1ns/1ps
module tb;
   localparam int EC = 400; // shortened erase time
   localparam int SE = 10; // sleep entry
   localparam int WS = 10; // short wake
   localparam int WL = 20; // long wake
   localparam logic [7:0] MK = 8'hA5; // arbitrary value
   localparam logic [7:0] DV = 8'h4E; // arbitrary value
   localparam logic [7:0] MT = 8'h71; // arbitrary value
   localparam logic [7:0] CP = 8'h17; // arbitrary value
   logic ref_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [2:0] lvl = 3'h0; // protect level
   logic inv = 1'b0; // protect invert
   wire cs_n, sclk, write_enable_latch, busy, sleep, stby, rb_en, er_all, er_done;
   wire [3:0] host_io, pin, dut_io, dut_oe_n;
   int errors = 0;
   int cmp_count = 0;
   int n_erase = 0; // erase starts seen
   int n_done = 0; // erase ends seen
   int cycles = 0;
   logic [47:0] g;
   // id read table: opcode, address bits, address, lanes, read clocks, answer
   logic [7:0] t_op [6] = '{8'h9F, 8'h90, 8'h90, 8'h92, 8'h94, 8'hAB};
   int t_ab [6] = '{0, 24, 24, 24, 24, 24};
   logic [23:0] t_ad [6] = '{24'h00_0000, 24'h00_0000, 24'h00_0001, 24'h00_0000,
      24'h00_0001, 24'h00_0000};
   int t_ln [6] = '{1, 1, 1, 2, 4, 1};
   int t_nc [6] = '{24, 16, 16, 8, 4, 16};
   logic [47:0] t_ex [6] = '{{24'h0, MK, MT, CP}, {32'h0, MK, DV}, {32'h0, DV, MK},
      {32'h0, MK, DV}, {32'h0, DV, MK}, {32'h0, DV, DV}};
   always #50 ref_clk_i = ~ref_clk_i;
   // pin level: device wins where it enables its driver
   assign pin = (dut_io & ~dut_oe_n) | (host_io & dut_oe_n);
   sfe_host_model sfe_host_model_i (.ref_clk_i(ref_clk_i), .io_pin_i(pin), .cs_n_o(cs_n),
      .sclk_o(sclk), .io_drv_o(host_io));
   sfe_cmd #(.MAKER_ID(MK), .DEVICE_ID(DV), .MEM_TYPE(MT), .CAPACITY(CP), .POWERUP_CYCLES(10),
      .ERASE_CYCLES(EC), .SLEEP_ENTRY_CYCLES(SE), .WAKE_SHORT_CYCLES(WS),
      .WAKE_LONG_CYCLES(WL)) sfe_cmd_i (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
      .cs_n_i(cs_n), .sclk_i(sclk), .io_i(pin), .io_o(dut_io), .io_oe_n_o(dut_oe_n),
      .protect_level_bits_i(lvl), .protect_invert_bit_i(inv), .write_enable_latch_o(write_enable_latch),
      .program_busy_flag_o(busy), .deep_sleep_o(sleep), .standby_o(stby),
      .busy_output_enable_o(rb_en), .erase_all_o(er_all), .erase_done_o(er_done));
   // erase start counter and hang guard
   always @(posedge ref_clk_i) begin
      cycles++;
      if (er_all === 1'b1) n_erase++;
      if (er_done === 1'b1) n_done++;
      if (cycles == 40000) begin
         errors++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   // bounded wait for standby after a timed interval
   task automatic wait_standby();
      for (int i = 0; i < 3000 && stby !== 1'b1; i++) wait_clk(1);
      chk(stby, 1);
   endtask
   // opcode-only frame, then let the decision land
   task automatic op(input logic [7:0] c);
      sfe_host_model_i.xfer(c, 0, 24'h00_0000, 1, 0, g);
      wait_clk(4);
   endtask
   initial begin
      wait_clk(10);
      reset_n_i = 1'b1;
      wait_standby();
      chk(sleep, 0);
      chk(dut_oe_n, 4'hF);
      $display("test powerup done");
      for (int i = 0; i < 6; i++) begin
         sfe_host_model_i.xfer(t_op[i], t_ab[i], t_ad[i], t_ln[i], t_nc[i], g);
         chk(g, t_ex[i]);
      end
      $display("test id reads done");
      sfe_host_model_i.xfer(8'h70, 1, 24'h00_0000, 1, 0, g);
      wait_clk(4);
      chk(rb_en, 0);
      op(8'h70);
      chk(rb_en, 1);
      chk({dut_oe_n, dut_io[1]}, {4'hD, 1'b1});
      op(8'h60);
      chk(n_erase, 0);
      op(8'h06);
      chk(write_enable_latch, 1);
      lvl = 3'h1;
      op(8'h60);
      chk({n_erase, write_enable_latch}, 1);
      lvl = 3'h0;
      sfe_host_model_i.xfer(8'h60, 1, 24'h00_0000, 1, 0, g);
      wait_clk(4);
      chk({n_erase, busy}, 0);
      lvl = 3'h7;
      inv = 1'b1;
      op(8'hC7);
      chk({n_erase, busy, write_enable_latch}, 6);
      chk(dut_io[1], 0);
      op(8'hB9);
      op(8'hAB);
      sfe_host_model_i.xfer(8'h9F, 0, 24'h00_0000, 1, 8, g);
      chk(g, 0);
      chk({busy, sleep}, 2);
      wait_standby();
      chk({n_erase, sleep}, 2);
      $display("test erase done");
      op(8'hB9);
      wait_clk(SE + 5);
      chk({sleep, dut_io[1]}, 2);
      chk(n_done, 1);
      op(8'h06);
      chk(write_enable_latch, 0);
      op(8'hAB);
      chk(sleep, 0);
      wait_clk(WS + 5);
      chk(stby, 1);
      op(8'hB9);
      wait_clk(SE + 5);
      sfe_host_model_i.xfer(8'hAB, 24, 24'h00_0000, 1, 16, g);
      chk(g, {32'h0, DV, DV});
      wait_clk(WL + 5);
      chk({sleep, stby}, 1);
      op(8'h80);
      chk({rb_en, dut_oe_n}, 5'h0F);
      $display("test sleep done");
      op(8'hB9);
      wait_clk(SE + 5);
      reset_n_i = 1'b0;
      wait_clk(3);
      reset_n_i = 1'b1;
      wait_standby();
      chk(sleep, 0);
      $display("test reset done");
      report_and_stop();
   end
endmodule
